//--- ptc_pkg.sv
// ====================
// shared constants and types for the periodic timer block
package ptc_pkg;

   // ====================
   // geometry
   localparam int PTC_CHANNELS     = 2;   // channel 0 wide, channel 1 narrow
   localparam int PTC_CNT_W        = 16;  // storage width of every counter
   localparam int PTC_WIDTH_WIDE   = 16;  // implemented bits, channel 0
   localparam int PTC_WIDTH_NARROW = 10;  // implemented bits, channel 1
   localparam int PTC_ADDR_W       = 8;   // avalon byte address width
   localparam int PTC_DATA_W       = 32;  // avalon data width
   localparam int PTC_BE_W         = 4;   // byte enables

   // ====================
   // address decode fields
   localparam int PTC_CH_BIT   = 5;  // address bit selecting the channel
   localparam int PTC_IDX_HI   = 4;  // register index, high bit
   localparam int PTC_IDX_LO   = 2;  // register index, low bit
   localparam int PTC_TOP_LO   = 6;  // address bits from here up must be zero

   // register indices inside one channel (byte offset = index * 4)
   localparam logic [2:0] PTC_IDX_RUN       = 3'h0;  // counter run bit
   localparam logic [2:0] PTC_IDX_CTRL      = 3'h1;  // timer_control_second
   localparam logic [2:0] PTC_IDX_FLAGS     = 3'h2;  // match flags, write 1 clears
   localparam logic [2:0] PTC_IDX_CMPA_LO   = 3'h3;  // compare_a_value low byte
   localparam logic [2:0] PTC_IDX_CMPA_HI   = 3'h4;  // compare_a_value high byte
   localparam logic [2:0] PTC_IDX_PERIOD_LO = 3'h5;  // period low byte
   localparam logic [2:0] PTC_IDX_PERIOD_HI = 3'h6;  // period high byte
   localparam logic [2:0] PTC_IDX_COUNT     = 3'h7;  // live counter, read only

   // ====================
   // field positions and reset values
   localparam int PTC_RUN_BIT    = 0;  // counter_run_bit in run register
   localparam int PTC_FLAG_A_BIT = 0;  // compare_a_flag
   localparam int PTC_FLAG_P_BIT = 1;  // period_match_flag

   localparam logic [7:0]  PTC_BYTE_RESET = 8'h00;   // every byte register
   localparam logic [15:0] PTC_CNT_RESET  = 16'h0000;
   localparam logic [15:0] PTC_CNT_ONE    = 16'h0001;
   localparam logic [15:0] PTC_FULL_MASK  = 16'hFFFF;

   // ====================
   // modes and output functions
   typedef enum logic [1:0] {
      PTC_MODE_COMPARE = 2'b00,  // compare match output
      PTC_MODE_CAPTURE = 2'b01,  // capture input, not built here
      PTC_MODE_PWM     = 2'b10,  // pwm output
      PTC_MODE_TIMER   = 2'b11   // timer/counter, pin released
   } ptc_mode_type;

   // output function codes in compare match mode
   localparam logic [1:0] PTC_IO_CM_NONE   = 2'h0;
   localparam logic [1:0] PTC_IO_CM_LOW    = 2'h1;
   localparam logic [1:0] PTC_IO_CM_HIGH   = 2'h2;
   localparam logic [1:0] PTC_IO_CM_TOGGLE = 2'h3;

   // output function codes in pwm mode
   localparam logic [1:0] PTC_IO_PWM_INACTIVE = 2'h0;
   localparam logic [1:0] PTC_IO_PWM_ACTIVE   = 2'h1;
   localparam logic [1:0] PTC_IO_PWM_WAVE     = 2'h2;

   // timer_control_second layout, bit 7 down to bit 0
   typedef struct packed {
      ptc_mode_type mode;         // mode_select_high, mode_select_low
      logic [1:0]   out_func;     // output_function_high, output_function_low
      logic         out_ctrl;     // output_control_bit
      logic         out_invert;   // output_invert_bit
      logic         trig_src;     // stored only, capture is not built
      logic         clear_sel;    // clear_select
   } ptc_ctrl_type;

endpackage : ptc_pkg

//--- ptc_periodic_timer.sv
`timescale 1ns/1ns
module ptc_periodic_timer
   import ptc_pkg::*;
(
   // clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   rst,
   // avalon-mm slave
   input  wire logic [ptc_pkg::PTC_ADDR_W-1:0]         address,
   input  wire logic                                   read,
   input  wire logic                                   write,
   input  wire logic [ptc_pkg::PTC_DATA_W-1:0]         writedata,
   input  wire logic [ptc_pkg::PTC_BE_W-1:0]           byteenable,
   output logic      [ptc_pkg::PTC_DATA_W-1:0]         readdata,
   output logic                                        waitrequest,
   // timer output pins, one per channel
   output logic      [ptc_pkg::PTC_CHANNELS-1:0]       timer_output_pin,
   output logic      [ptc_pkg::PTC_CHANNELS-1:0]       timer_output_pin_oe
);
   import ptc_pkg::*;

   // ====================
   // bus slave

   logic                   wait_reg;     // high while idle or first cycle
   logic                   wait_next;    // next waitrequest
   logic [PTC_DATA_W-1:0]  rdata_reg;    // captured read word
   logic [PTC_DATA_W-1:0]  rdata_next;   // next read word
   logic                   bus_req;      // any request present
   logic                   wr_fire;      // write completes on this edge
   logic                   rd_take;      // read word captured on this edge
   logic                   addr_ok;      // aligned and inside the map
   logic                   sel_ch;       // addressed channel
   logic [2:0]             sel_idx;      // addressed register index
   logic [PTC_DATA_W-1:0]  rd_word [PTC_CHANNELS];  // per channel read mux

   // every request waits exactly one cycle, then completes
   assign bus_req   = read | write;
   assign wait_next = ~(bus_req & wait_reg);
   assign wr_fire   = write & ~wait_reg & byteenable[0];
   assign rd_take   = read & wait_reg;

   // address decode
   assign addr_ok = (address[1:0] == 2'h0) &&
                    (address[PTC_ADDR_W-1:PTC_TOP_LO] == 2'h0);
   assign sel_ch  = address[PTC_CH_BIT];
   assign sel_idx = address[PTC_IDX_HI:PTC_IDX_LO];

   // unmapped or misaligned reads answer zero
   assign rdata_next = addr_ok ? rd_word[sel_ch] : {PTC_DATA_W{1'b0}};

   // handshake flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= wait_next;
      end
   end

   // read data capture, held until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= {PTC_DATA_W{1'b0}};
      end else if (rd_take) begin
         rdata_reg <= rdata_next;
      end
   end

   assign waitrequest = wait_reg;
   assign readdata    = rdata_reg;

   // ====================
   // timer channels

   genvar gi;
   generate
      for (gi = 0; gi < PTC_CHANNELS; gi = gi + 1) begin : g_ch
         // implemented width and the mask that keeps spare bits at zero
         localparam int         W    = (gi == 0) ? PTC_WIDTH_WIDE : PTC_WIDTH_NARROW;
         localparam logic [15:0] MASK = PTC_FULL_MASK >> (PTC_CNT_W - W);


         // registers

         ptc_ctrl_type  ctrl_reg;      // timer_control_second
         logic          run_reg;       // counter_run_bit
         logic          run_prev_reg;  // run bit one cycle ago
         logic          flag_a_reg;    // compare_a_flag
         logic          flag_p_reg;    // period_match_flag
         logic [15:0]   cmpa_reg;      // compare_a_value
         logic [15:0]   period_reg;    // period_value
         logic [15:0]   cnt_reg;       // up-counter
         logic          level_reg;     // compare mode output level
         logic          pin_reg;       // pin level
         logic          oe_reg;        // pin enable


         // next values and decode

         logic          wr_this;       // write aimed at this channel
         logic [7:0]    wbyte;         // written byte
         logic          clr_a;         // software clears compare_a_flag
         logic          clr_p;         // software clears period_match_flag
         logic [15:0]   cnt_inc;       // counter plus one, wrapped at W
         logic          match_a;       // comparator a
         logic          match_p;       // comparator p
         logic          is_pwm;        // pwm mode
         logic          is_cmp_like;   // compare or timer/counter mode
         logic          clear_on_a;    // comparator a clears the counter
         logic          set_a;         // raise compare_a_flag
         logic          set_p;         // raise period_match_flag
         logic          cnt_clear;     // counter returns to zero
         logic [15:0]   cnt_next;      // next counter
         logic          run_rise;      // run bit went low to high
         logic          cm_action;     // compare-a level action taken
         logic          cm_level;      // level asked by output function
         logic          level_next;    // next compare output level
         logic          pwm_raw;       // pwm in its active phase
         logic          pwm_level;     // pwm level before inversion
         logic          pin_next;      // next pin level
         logic          oe_next;       // next pin enable

         assign wr_this = wr_fire & addr_ok & (sel_ch == 1'(gi));
         assign wbyte   = writedata[7:0];
         assign clr_a   = wr_this & (sel_idx == PTC_IDX_FLAGS) & wbyte[PTC_FLAG_A_BIT];
         assign clr_p   = wr_this & (sel_idx == PTC_IDX_FLAGS) & wbyte[PTC_FLAG_P_BIT];

         // comparators look at the value the counter is about to take
         assign cnt_inc = 16'(cnt_reg + PTC_CNT_ONE) & MASK;
         assign match_a = run_reg & (cnt_inc == cmpa_reg);
         // a zero period matches on the wrap, i.e. the overflow
         assign match_p = run_reg & (cnt_inc == period_reg);

         // mode decode
         assign is_pwm      = (ctrl_reg.mode == PTC_MODE_PWM);
         assign is_cmp_like = (ctrl_reg.mode == PTC_MODE_COMPARE) |
                              (ctrl_reg.mode == PTC_MODE_TIMER);
         // clear-select only counts in compare and timer/counter modes
         assign clear_on_a  = is_cmp_like & ctrl_reg.clear_sel;

         // flag events
         assign set_a     = match_a;
         assign set_p     = match_p & ~clear_on_a;
         assign cnt_clear = clear_on_a ? match_a : match_p;

         // counter holds while stopped
         assign cnt_next = ~run_reg  ? cnt_reg :
                           cnt_clear ? PTC_CNT_RESET : cnt_inc;

         // compare mode output level
         assign run_rise  = run_reg & ~run_prev_reg;
         assign cm_action = (ctrl_reg.mode == PTC_MODE_COMPARE) & match_a &
                            (ctrl_reg.out_func != PTC_IO_CM_NONE);
         assign cm_level  = (ctrl_reg.out_func == PTC_IO_CM_LOW)  ? 1'b0 :
                            (ctrl_reg.out_func == PTC_IO_CM_HIGH) ? 1'b1 :
                            ~level_reg;
         assign level_next = run_rise  ? ctrl_reg.out_ctrl :
                             cm_action ? cm_level : level_reg;

         // pwm: active while the counter is below compare-a
         assign pwm_raw   = cnt_reg < cmpa_reg;
         assign pwm_level =
            (ctrl_reg.out_func == PTC_IO_PWM_ACTIVE) ? ctrl_reg.out_ctrl :
            (ctrl_reg.out_func == PTC_IO_PWM_WAVE)   ?
               (pwm_raw ? ctrl_reg.out_ctrl : ~ctrl_reg.out_ctrl) :
            ~ctrl_reg.out_ctrl;

         // pin drive, inversion after the level choice
         assign pin_next = is_pwm ? (pwm_level ^ ctrl_reg.out_invert) :
                           (ctrl_reg.mode == PTC_MODE_COMPARE) ?
                              (level_next ^ ctrl_reg.out_invert) : pin_reg;
         // timer/counter and capture modes release the pin
         assign oe_next  = is_pwm | (ctrl_reg.mode == PTC_MODE_COMPARE);

         // read mux, narrow bits above W were never stored
         assign rd_word[gi] =
            (sel_idx == PTC_IDX_RUN)       ? {31'h0, run_reg} :
            (sel_idx == PTC_IDX_CTRL)      ? {24'h0, ctrl_reg} :
            (sel_idx == PTC_IDX_FLAGS)     ? {30'h0, flag_p_reg, flag_a_reg} :
            (sel_idx == PTC_IDX_CMPA_LO)   ? {24'h0, cmpa_reg[7:0]} :
            (sel_idx == PTC_IDX_CMPA_HI)   ? {24'h0, cmpa_reg[15:8]} :
            (sel_idx == PTC_IDX_PERIOD_LO) ? {24'h0, period_reg[7:0]} :
            (sel_idx == PTC_IDX_PERIOD_HI) ? {24'h0, period_reg[15:8]} :
            {16'h0, cnt_reg};


         // software registers

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               ctrl_reg   <= ptc_ctrl_type'(PTC_BYTE_RESET);
               run_reg    <= 1'b0;
               cmpa_reg   <= PTC_CNT_RESET;
               period_reg <= PTC_CNT_RESET;
            end else if (wr_this) begin
               // one register per write, spare bits masked off
               case (sel_idx)
                  PTC_IDX_RUN: begin
                     run_reg <= wbyte[PTC_RUN_BIT];
                  end
                  PTC_IDX_CTRL: begin
                     ctrl_reg <= ptc_ctrl_type'(wbyte);
                  end
                  PTC_IDX_CMPA_LO: begin
                     cmpa_reg[7:0] <= wbyte & MASK[7:0];
                  end
                  PTC_IDX_CMPA_HI: begin
                     cmpa_reg[15:8] <= wbyte & MASK[15:8];
                  end
                  PTC_IDX_PERIOD_LO: begin
                     period_reg[7:0] <= wbyte & MASK[7:0];
                  end
                  PTC_IDX_PERIOD_HI: begin
                     period_reg[15:8] <= wbyte & MASK[15:8];
                  end
                  default: begin
                     // flags and counter have their own processes
                  end
               endcase
            end
         end


         // match flags, a new match beats a clear in the same cycle

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               flag_a_reg <= 1'b0;
               flag_p_reg <= 1'b0;
            end else begin
               flag_a_reg <= set_a | (flag_a_reg & ~clr_a);
               flag_p_reg <= set_p | (flag_p_reg & ~clr_p);
            end
         end


         // counter and run edge tracking

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_reg      <= PTC_CNT_RESET;
               run_prev_reg <= 1'b0;
            end else begin
               cnt_reg      <= cnt_next;
               run_prev_reg <= run_reg;
            end
         end


         // output stage

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               level_reg <= 1'b0;
               pin_reg   <= 1'b0;
               oe_reg    <= 1'b0;
            end else begin
               level_reg <= level_next;
               pin_reg   <= pin_next;
               oe_reg    <= oe_next;
            end
         end

         assign timer_output_pin[gi]    = pin_reg;
         assign timer_output_pin_oe[gi] = oe_reg;
      end
   endgenerate

endmodule // ptc_periodic_timer

//--- ptc_timer_properties.sv
`timescale 1ns/1ns
// =====================================================================
// checker: bus handshake and pin behaviour seen from the top ports
// =====================================================================
module ptc_timer_properties
   import ptc_pkg::*;
(
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst,
   // avalon-mm slave
   input  wire logic [ptc_pkg::PTC_ADDR_W-1:0]      address,
   input  wire logic                                read,
   input  wire logic                                write,
   input  wire logic [ptc_pkg::PTC_DATA_W-1:0]      writedata,
   input  wire logic [ptc_pkg::PTC_BE_W-1:0]        byteenable,
   input  wire logic [ptc_pkg::PTC_DATA_W-1:0]      readdata,
   input  wire logic                                waitrequest,
   // timer output pins
   input  wire logic [ptc_pkg::PTC_CHANNELS-1:0]    timer_output_pin,
   input  wire logic [ptc_pkg::PTC_CHANNELS-1:0]    timer_output_pin_oe
);
   // shadow of what software wrote, so pin rules can be judged
   wire logic         wr_done = write && !waitrequest && byteenable[0];  // write lands
   wire logic         hit0    = wr_done && (address[7:5] == 3'h0);       // channel 0 write
   wire logic         hit1    = wr_done && (address[7:5] == 3'h1);       // channel 1 write
   wire ptc_ctrl_type ctl_wd  = ptc_ctrl_type'(writedata[7:0]);          // control image
   ptc_ctrl_type      ctl0_reg;                                          // channel 0 control
   ptc_ctrl_type      ctl1_reg;                                          // channel 1 control
   logic              run0_reg;                                          // channel 0 run bit
   logic [1:0]        quiet0_reg;                                        // ticks since ch0 write
   logic [1:0]        quiet1_reg;                                        // ticks since ch1 write
   wire logic [1:0]   quiet0_next = hit0 ? 2'h0 : quiet0_reg + {1'b0, quiet0_reg != 2'h3};
   wire logic [1:0]   quiet1_next = hit1 ? 2'h0 : quiet1_reg + {1'b0, quiet1_reg != 2'h3};
   // shadow registers follow completed writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl0_reg   <= '0;
         ctl1_reg   <= '0;
         run0_reg   <= 1'b0;
         quiet0_reg <= 2'h0;
         quiet1_reg <= 2'h0;
      end else begin
         if (hit0 && address[4:2] == PTC_IDX_CTRL) ctl0_reg <= ctl_wd;
         if (hit1 && address[4:2] == PTC_IDX_CTRL) ctl1_reg <= ctl_wd;
         if (hit0 && address[4:2] == PTC_IDX_RUN) run0_reg <= writedata[0];
         quiet0_reg <= quiet0_next;
         quiet1_reg <= quiet1_next;
      end
   end
   // ====================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered in one cycle");
   bus_single_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   narrow_hi_zero_a: assert property (read && waitrequest && address == 8'h38 |=> readdata[7:2] == 6'h00)
      else $error("narrow period high byte upper bits not zero");
   unmapped_zero_a: assert property (read && waitrequest && address[7:6] != 2'h0 |=> readdata == '0)
      else $error("unmapped read not zero");
   pin_released_a: assert property (quiet0_reg == 2'h3 && ctl0_reg.mode == PTC_MODE_TIMER
      |-> !timer_output_pin_oe[0]) else $error("pin driven in timer mode");
   pin_driven_a: assert property (quiet0_reg == 2'h3 && ctl0_reg.mode == PTC_MODE_COMPARE
      |-> timer_output_pin_oe[0]) else $error("pin not driven in compare mode");
   hold_level_a: assert property (quiet0_reg == 2'h3 && ctl0_reg.mode == PTC_MODE_COMPARE
      && ctl0_reg.out_func == PTC_IO_CM_NONE |-> $stable(timer_output_pin[0]))
      else $error("pin moved with no-change function");
   run_load_a: assert property ($rose(run0_reg) && ctl0_reg.mode == PTC_MODE_COMPARE
      && ctl0_reg.out_func == PTC_IO_CM_NONE
      |-> ##[1:2] timer_output_pin[0] == (ctl0_reg.out_ctrl ^ ctl0_reg.out_invert))
      else $error("initial level not loaded on run rise");
   pwm_inactive_a: assert property (quiet1_reg == 2'h3 && ctl1_reg.mode == PTC_MODE_PWM
      && ctl1_reg.out_func == PTC_IO_PWM_INACTIVE
      |-> timer_output_pin[1] == (!ctl1_reg.out_ctrl ^ ctl1_reg.out_invert))
      else $error("forced inactive level wrong");
   pwm_active_a: assert property (quiet1_reg == 2'h3 && ctl1_reg.mode == PTC_MODE_PWM
      && ctl1_reg.out_func == PTC_IO_PWM_ACTIVE
      |-> timer_output_pin[1] == (ctl1_reg.out_ctrl ^ ctl1_reg.out_invert))
      else $error("forced active level wrong");
endmodule // ptc_timer_properties

bind ptc_periodic_timer ptc_timer_properties u_props (
   .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .timer_output_pin(timer_output_pin),
   .timer_output_pin_oe(timer_output_pin_oe));

//--- ptc_pin_load.sv
`timescale 1ns/1ns
// =====================================================================
// board load on one timer pin: pull-down, counts high ticks and rises
// =====================================================================
module ptc_pin_load (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // pin as the board sees it
   input  wire logic        pin,
   input  wire logic        pin_oe,
   // observation counters
   output logic      [15:0] high_cnt,
   output logic      [15:0] rise_cnt
);
   wire logic line_lvl = pin_oe ? pin : 1'b0;  // pull-down holds a released line low
   logic      prev_reg;                          // line level one tick ago
   // count ticks spent high and low-to-high edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_cnt <= 16'h0000;
         rise_cnt <= 16'h0000;
         prev_reg <= 1'b0;
      end else begin
         high_cnt <= high_cnt + {15'h0000, line_lvl};
         rise_cnt <= rise_cnt + {15'h0000, line_lvl && !prev_reg};
         prev_reg <= line_lvl;
      end
   end
endmodule // ptc_pin_load

//--- tb.sv
`timescale 1ns/1ns
module tb;
   import ptc_pkg::*;
   // ====================
   // signals
   logic        clk;
   logic        rst;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [1:0]  pin;
   logic [1:0]  pin_oe;
   logic [15:0] high_cnt [2];                  // per-pin high tick count
   logic [15:0] rise_cnt [2];                  // per-pin rising edge count
   logic [31:0] q;                             // last word read
   logic [15:0] snap;                          // counter snapshot
   int          n_mismatch = 0;
   int          checks_done = 0;
   logic [7:0]  pwm_ctl [6] = '{8'hA8, 8'hAC, 8'hA0, 8'h98, 8'h88, 8'h8C};  // pwm setups
   logic [15:0] pwm_hi  [6] = '{16'h0010, 16'h0030, 16'h0030, 16'h0040, 16'h0000, 16'h0040};
   ptc_periodic_timer u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe));
   for (genvar g = 0; g < 2; g++) begin : g_load
      ptc_pin_load u_load (.clk(clk), .rst(rst), .pin(pin[g]), .pin_oe(pin_oe[g]),
         .high_cnt(high_cnt[g]), .rise_cnt(rise_cnt[g]));
   end
   // ====================
   // tasks
   function automatic logic [7:0] ra(input logic ch, input logic [2:0] idx);
      return {2'h0, ch, idx, 2'h0};
   endfunction
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one avalon access; waitrequest is judged mid-cycle, before the edge that ends it
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address   <= a;
      write     <= wr;
      read      <= !wr;
      writedata <= {24'h000000, d};
      do begin
         @(negedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      @(posedge clk);
      write <= 1'b0;
      read  <= 1'b0;
      check("bus answer", 32'h1, {31'h0, n < 20});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ====================
   // clock, watchdog, tests
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #50000;
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen timeout");
      test_done();
   end
   initial begin
      rst = 1'b1;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // every register of both channels starts at zero, unmapped reads zero
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 8; i++) begin
            bus(1'b0, ra(c[0], i[2:0]), 8'h00);
            check("reset value", 32'h0, q);
         end
      end
      bus(1'b0, 8'h40, 8'h00);
      check("unmapped read", 32'h0, q);
      $display("test reset done");
      // period bytes read back; narrow high byte keeps two bits
      bus(1'b1, ra(0, PTC_IDX_PERIOD_HI), 8'hAB);
      bus(1'b0, ra(0, PTC_IDX_PERIOD_HI), 8'h00);
      check("wide period high", 32'hAB, q);
      bus(1'b1, ra(1, PTC_IDX_PERIOD_HI), 8'hFF);
      bus(1'b0, ra(1, PTC_IDX_PERIOD_HI), 8'h00);
      check("narrow period high", 32'h03, q);
      bus(1'b1, ra(0, PTC_IDX_PERIOD_HI), 8'h00);
      bus(1'b1, ra(1, PTC_IDX_PERIOD_HI), 8'h00);
      $display("test period bytes done");
      // compare mode: period 0x30, compare-a 0x20, initial high, drive low
      bus(1'b1, ra(0, PTC_IDX_PERIOD_LO), 8'h30);
      bus(1'b1, ra(0, PTC_IDX_CMPA_LO), 8'h20);
      bus(1'b1, ra(0, PTC_IDX_CTRL), 8'h18);
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h01);
      cyc(2);
      check("initial level", 32'h1, {31'h0, pin[0]});
      cyc(80);
      check("level after match", 32'h0, {31'h0, pin[0]});
      bus(1'b0, ra(0, PTC_IDX_FLAGS), 8'h00);
      check("both flags", 32'h3, q);
      bus(1'b0, ra(0, PTC_IDX_COUNT), 8'h00);
      check("count below period", 32'h1, {31'h0, q[15:0] < 16'h0030});
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h00);
      bus(1'b1, ra(0, PTC_IDX_FLAGS), 8'h03);
      bus(1'b0, ra(0, PTC_IDX_FLAGS), 8'h00);
      check("flags cleared", 32'h0, q);
      // no-change function with inversion holds the inverted initial level
      bus(1'b1, ra(0, PTC_IDX_CTRL), 8'h0C);
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h01);
      cyc(60);
      check("no-change level", 32'h0, {31'h0, pin[0]});
      bus(1'b0, ra(0, PTC_IDX_FLAGS), 8'h00);
      check("flag a with no change", 32'h1, {31'h0, q[0]});
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h00);
      // drive-high, then toggle once per period of 0x30 ticks
      bus(1'b1, ra(0, PTC_IDX_CTRL), 8'h20);
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h01);
      cyc(60);
      check("level high after match", 32'h1, {31'h0, pin[0]});
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h00);
      bus(1'b1, ra(0, PTC_IDX_CTRL), 8'h30);
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h01);
      cyc(60);
      snap = rise_cnt[0];
      cyc(96);
      check("toggle rises", 32'h1, {16'h0, rise_cnt[0] - snap});
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h00);
      $display("test compare mode done");
      // timer mode, compare-a clears, period below compare-a raises nothing
      bus(1'b1, ra(0, PTC_IDX_FLAGS), 8'h03);
      bus(1'b1, ra(0, PTC_IDX_CMPA_LO), 8'h30);
      bus(1'b1, ra(0, PTC_IDX_PERIOD_LO), 8'h08);
      bus(1'b1, ra(0, PTC_IDX_CTRL), 8'hC1);
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h01);
      cyc(110);
      bus(1'b0, ra(0, PTC_IDX_FLAGS), 8'h00);
      check("only flag a", 32'h1, q);
      bus(1'b0, ra(0, PTC_IDX_COUNT), 8'h00);
      check("count below compare-a", 32'h1, {31'h0, q[15:0] < 16'h0030});
      check("pin released", 32'h0, {31'h0, pin_oe[0]});
      bus(1'b1, ra(0, PTC_IDX_RUN), 8'h00);
      $display("test timer mode done");
      // pwm on the narrow channel: period 0x10, duty 0x04, each setup over 64 ticks
      bus(1'b1, ra(1, PTC_IDX_PERIOD_LO), 8'h10);
      bus(1'b1, ra(1, PTC_IDX_CMPA_LO), 8'h04);
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, ra(1, PTC_IDX_CTRL), pwm_ctl[k]);
         bus(1'b1, ra(1, PTC_IDX_RUN), 8'h01);
         cyc(8);
         snap = high_cnt[1];
         cyc(64);
         check("pwm high ticks", {16'h0, pwm_hi[k]}, {16'h0, high_cnt[1] - snap});
         bus(1'b1, ra(1, PTC_IDX_RUN), 8'h00);
      end
      bus(1'b0, ra(1, PTC_IDX_FLAGS), 8'h00);
      check("pwm flags", 32'h3, q);
      $display("test pwm done");
      test_done();
   end
endmodule // tb
